// [rtl/sad_pkg.sv]
// Constants, region table and types shared by the system address decoder
package sad_pkg;

	// Clock figures
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned PERIPH_HZ     = 25_000_000;
	localparam int unsigned PERIPH_HALF   = CLK_HZ / (2 * PERIPH_HZ);
	localparam int unsigned FLASH_SCK_MAX = 50_000_000;
	localparam int unsigned I2C_SCL_MAX   = 100_000;
	// Least divider that keeps each serial clock at or below its ceiling
	localparam int unsigned FLASH_SCK_DIV_C = (PERIPH_HZ + FLASH_SCK_MAX - 1) / FLASH_SCK_MAX;
	localparam int unsigned FLASH_SCK_DIV   = (FLASH_SCK_DIV_C < 1) ? 1 : FLASH_SCK_DIV_C;
	localparam int unsigned I2C_SCL_DIV     = (PERIPH_HZ + I2C_SCL_MAX - 1) / I2C_SCL_MAX;

	// Direct-read fetch commands by line count
	localparam logic [7:0] CMD_FAST_SINGLE = 8'h0B;
	localparam logic [7:0] CMD_FAST_DUAL   = 8'hBB;
	localparam logic [7:0] CMD_FAST_QUAD   = 8'hEB;
	localparam int unsigned QUEUE_DEPTH    = 16;
	localparam int unsigned I2C_ADDR_BITS  = 7;

	// Mode selector register
	localparam logic [31:0] SEL_ADDR      = 32'hE400_0000;
	localparam logic [31:0] SEL_MASK      = 32'h0000_0FFF;
	localparam int unsigned SEL_MODE_BIT  = 1;
	localparam logic        SEL_MODE_RST  = 1'b0;

	// Target regions, index order is the target select bit order
	localparam int unsigned NRGN = 21;
	typedef enum int unsigned {
		RG_DBG, RG_HCR, RG_ILM, RG_CLINT, RG_CMU, RG_INTREG, RG_PLIC, RG_EXTBUS,
		RG_FLASH_MAP, RG_SDRAM, RG_DLM, RG_GPINT, RG_VERSION, RG_GPIO, RG_I2C,
		RG_FLASH_DREG, RG_FLASH_CMD, RG_CARD, RG_UART, RG_RAM0, RG_RAM1
	} sad_rgn_t;

	localparam logic [31:0] RGN_BASE [0:NRGN-1] = '{
		32'h0000_0000, 32'h0000_8000, 32'h0180_0000, 32'h0200_0000,
		32'h0210_0000, 32'h0210_1000, 32'h0C00_0000, 32'h2000_0000,
		32'h4000_0000, 32'h6000_0000, 32'h7000_0000, 32'hE000_0000,
		32'hE1FF_F000, 32'hE400_1000, 32'hE400_2000, 32'hE400_3000,
		32'hE400_4000, 32'hE400_5000, 32'hE400_6000, 32'hE880_0000,
		32'hE890_0000
	};
	// Window size minus one
	localparam logic [31:0] RGN_MASK [0:NRGN-1] = '{
		32'h0000_3FFF, 32'h0000_7FFF, 32'h0001_FFFF, 32'h0000_FFFF,
		32'h0000_0FFF, 32'h0000_0FFF, 32'h003F_FFFF, 32'h000F_FFFF,
		32'h01FF_FFFF, 32'h0FFF_FFFF, 32'h0000_FFFF, 32'h0000_0FFF,
		32'h0000_0FFF, 32'h0000_0FFF, 32'h0000_0FFF, 32'h0000_0FFF,
		32'h0000_0FFF, 32'h0000_0FFF, 32'h0000_0FFF, 32'h0000_FFFF,
		32'h0000_FFFF
	};

	// Access sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_HOLD = 4'b0010,
		ST_FWD  = 4'b0100,
		ST_RESP = 4'b1000
	} sad_state_t;

endpackage

// [rtl/sad_path_sel.sv]
// Flash path mode selector register
`timescale 1ns/1ps
module sad_path_sel
	import sad_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        wr_en,
	input  wire logic [31:0] wdata,
	output logic             cmd_mode,
	output logic [31:0]      rdata
);

	logic mode_r;
	logic mode_nxt;

	// Only the mode bit is stored; the rest are reserved
	assign mode_nxt = wr_en ? wdata[SEL_MODE_BIT] : mode_r;

	// Direct-read path is live before any software runs
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			mode_r <= SEL_MODE_RST; // RL24
		else
			mode_r <= mode_nxt; // RL11
	end

	assign cmd_mode = mode_r;

	// Reserved bits read as zero
	always_comb
	begin
		rdata = 32'h0000_0000;
		rdata[SEL_MODE_BIT] = mode_r;
	end

	a_sel_write_lands : assert property (@(posedge sys_clk) disable iff (srst)
		wr_en |=> mode_r == $past(wdata[SEL_MODE_BIT])) // RL11
		else $error("selector bit did not take the written value");

endmodule

// [rtl/sad_decoder.sv]
// System address decoder with flash path steering and platform set-up
//
// Notes on behaviour
// [RL1] Debug registers: 16KB at zero
// [RL2] Hart context registers: 32KB at 0000_8000
// [RL3] Instruction local memory: 128KB at 0180_0000
// [RL4] Interruptor and timer: 64KB at 0200_0000
// [RL5] Clock management 4KB, internal regs next 4KB
// [RL6] Interrupt controller: 4MB at 0C00_0000
// [RL7] External bus 1MB at 2000_0000, unconnected
// [RL8] Data local memory: 64KB at 7000_0000
// [RL9] Flash contents mapped 32MB at 4000_0000
// [RL10] Flash register windows E400_3000 and E400_4000
// [RL11] Selector bit 1: 0 direct-read, 1 command
// [RL12] Software uses only the selected mode's windows
// [RL13] Direct-read fetch command 0B, BB or EB
// [RL14] Direct-read path fixed to single-line fetch
// [RL15] Command-mode queues hold 16 entries each
// [RL16] Flash serial clock at most 50 MHz
// [RL17] Calendar I2C window at E400_2000
// [RL18] I2C master, 7-bit addressing, at most 100 kHz
// [RL19] Card SPI window at E400_5000
// [RL20] SDRAM initialises itself after reset release
// [RL21] Processor and peripherals share one 25MHz clock
// [RL22] Atomics target only internal processor memories
// [RL23] Reserved or deselected windows answer bus error
// [RL24] Selector resets to direct-read mode
`timescale 1ns/1ps
module sad_decoder
	import sad_pkg::*;
#(
	parameter int unsigned FLASH_LINES = 1,
	parameter int unsigned QDEPTH      = sad_pkg::QUEUE_DEPTH
)
(
	input  wire logic               sys_clk,
	input  wire logic               srst,
	input  wire logic               cpu_req,
	input  wire logic [31:0]        cpu_addr,
	input  wire logic               cpu_we,
	input  wire logic [31:0]        cpu_wdata,
	output logic                    cpu_ready,
	output logic                    cpu_ack_r,
	output logic                    cpu_err_r,
	output logic [31:0]             cpu_rdata_r,
	output logic                    tgt_req_r,
	output logic [sad_pkg::NRGN-1:0] tgt_sel_r,
	output logic [31:0]             tgt_addr_r,
	output logic                    tgt_we_r,
	output logic [31:0]             tgt_wdata_r,
	input  wire logic               tgt_ack,
	input  wire logic [31:0]        tgt_rdata,
	output logic                    flash_cmd_mode_r,
	output logic [7:0]              flash_read_cmd_r,
	output logic [7:0]              flash_sck_div_r,
	output logic [4:0]              queue_depth_r,
	output logic [15:0]             i2c_scl_div_r,
	output logic [3:0]              i2c_addr_bits_r,
	output logic                    sdram_init_req_r,
	input  wire logic               sdram_init_done,
	output logic                    periph_clk_r
);

	// Refuse builds the logic cannot serve
	if (FLASH_LINES != 1) begin : g_bad_lines
		$error("direct-read path supports single-line fetch only");
	end
	if (QDEPTH != 16) begin : g_bad_depth
		$error("queue depth must be 16");
	end

	sad_state_t          state_r;
	sad_state_t          state_nxt;
	logic [NRGN-1:0]     hit;
	logic                sel_hit;
	logic                any_hit;
	logic                mode_clash;
	logic                bad_addr;
	logic                local_ans;
	logic                take;
	logic                sdram_ok_r;
	logic                cmd_mode;
	logic [31:0]         sel_rdata;
	logic                sel_wr;
	logic [1:0]          div_cnt_r;
	logic [7:0]          fetch_cmd;
	logic                resp_err_nxt;
	logic [31:0]         resp_data_nxt;

	// One comparator per window, base plus size-minus-one mask
	genvar gi;
	generate
		for (gi = 0; gi < NRGN; gi++) begin : g_hit
			assign hit[gi] = (cpu_addr & ~RGN_MASK[gi]) == RGN_BASE[gi]; // RL1 RL2 RL3 RL4 RL5 RL6 RL8 RL9
		end
	endgenerate

	// Selector register and fault classification
	assign sel_hit    = (cpu_addr & ~SEL_MASK) == SEL_ADDR; // RL11
	assign any_hit    = |hit;
	// Windows of the idle flash mode are refused, not forwarded
	assign mode_clash = cmd_mode ? (hit[RG_FLASH_MAP] | hit[RG_FLASH_DREG])
	                             : hit[RG_FLASH_CMD]; // RL10 RL12
	assign bad_addr   = (!any_hit && !sel_hit) || mode_clash; // RL23
	// Unconnected external bus answers locally with zero data
	assign local_ans  = bad_addr || sel_hit || hit[RG_EXTBUS]; // RL7
	assign take       = cpu_req && state_r == ST_IDLE;
	assign sel_wr     = take && sel_hit && cpu_we;
	assign cpu_ready  = state_r[0];

	sad_path_sel u_path_sel (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.wr_en    (sel_wr),
		.wdata    (cpu_wdata),
		.cmd_mode (cmd_mode),
		.rdata    (sel_rdata)
	);

	// Sequencer next state; SDRAM waits until its set-up has finished
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
				if (take)
				begin
					if (local_ans)
						state_nxt = ST_RESP;
					else if (hit[RG_SDRAM] && !sdram_ok_r)
						state_nxt = ST_HOLD; // RL20
					else
						state_nxt = ST_FWD;
				end
			ST_HOLD:
				if (sdram_ok_r)
					state_nxt = ST_FWD;
			ST_FWD:
				if (tgt_ack)
					state_nxt = ST_RESP;
			ST_RESP:
				state_nxt = ST_IDLE;
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// Answer data: selector contents, zero, or the target's word
	assign resp_err_nxt  = take && bad_addr; // RL23
	assign resp_data_nxt = (state_r == ST_FWD) ? tgt_rdata :
	                       (take && sel_hit && !cpu_we) ? sel_rdata : 32'h0000_0000;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Processor answer, one cycle wide
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			cpu_ack_r   <= 1'b0;
			cpu_err_r   <= 1'b0;
			cpu_rdata_r <= 32'h0000_0000;
		end
		else
		begin
			cpu_ack_r   <= (take && local_ans) || (state_r == ST_FWD && tgt_ack);
			cpu_err_r   <= resp_err_nxt;
			cpu_rdata_r <= resp_data_nxt;
		end
	end

	// Target side: request strobe one cycle, select held through the access
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			tgt_req_r <= 1'b0;
			tgt_sel_r <= '0;
		end
		else
		begin
			tgt_req_r <= state_nxt == ST_FWD && state_r != ST_FWD;
			if (take)
				tgt_sel_r <= local_ans ? '0 : hit; // RL17 RL19
			else if (state_nxt == ST_IDLE)
				tgt_sel_r <= '0;
		end
	end

	// Address and data captured once at take
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			tgt_addr_r  <= 32'h0000_0000;
			tgt_we_r    <= 1'b0;
			tgt_wdata_r <= 32'h0000_0000;
		end
		else if (take)
		begin
			tgt_addr_r  <= cpu_addr;
			tgt_we_r    <= cpu_we;
			tgt_wdata_r <= cpu_wdata;
		end
	end

	// SDRAM set-up is requested by hardware right after reset
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			sdram_ok_r       <= 1'b0;
			sdram_init_req_r <= 1'b0;
		end
		else
		begin
			sdram_ok_r       <= sdram_ok_r | sdram_init_done; // RL20
			sdram_init_req_r <= !(sdram_ok_r | sdram_init_done); // RL20
		end
	end

	// Fixed single-line fetch; other widths kept for completeness
	assign fetch_cmd = (FLASH_LINES == 4) ? CMD_FAST_QUAD :
	                   (FLASH_LINES == 2) ? CMD_FAST_DUAL : CMD_FAST_SINGLE; // RL13 RL14

	// Static peripheral settings and the flash mode copy, registered so outputs come from flops
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			flash_cmd_mode_r <= SEL_MODE_RST;
			flash_read_cmd_r <= 8'h00;
			flash_sck_div_r  <= 8'h00;
			queue_depth_r    <= 5'h00;
			i2c_scl_div_r    <= 16'h0000;
			i2c_addr_bits_r  <= 4'h0;
		end
		else
		begin
			flash_cmd_mode_r <= cmd_mode; // RL11
			flash_read_cmd_r <= fetch_cmd; // RL13
			flash_sck_div_r  <= 8'(FLASH_SCK_DIV); // RL16
			queue_depth_r    <= 5'(QDEPTH); // RL15
			i2c_scl_div_r    <= 16'(I2C_SCL_DIV); // RL18
			i2c_addr_bits_r  <= 4'(I2C_ADDR_BITS); // RL18
		end
	end

	// Shared peripheral clock derived by division; no second domain here
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			div_cnt_r    <= 2'h0;
			periph_clk_r <= 1'b0;
		end
		else if (div_cnt_r == 2'(PERIPH_HALF - 1))
		begin
			div_cnt_r    <= 2'h0;
			periph_clk_r <= !periph_clk_r; // RL21
		end
		else
			div_cnt_r <= div_cnt_r + 2'h1;
	end

	// Checks on the decoder's own behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_take_local;
		cpu_req && cpu_ready && local_ans;
	endsequence

	sequence s_one_ack;
		cpu_ack_r ##1 !cpu_ack_r;
	endsequence

	a_local_answer : assert property (s_take_local |=> s_one_ack) // RL23
		else $error("local answer not given next cycle");

	a_bad_err : assert property (cpu_req && cpu_ready && bad_addr |=> cpu_ack_r && cpu_err_r) // RL23
		else $error("reserved access not answered with error");

	a_dbg_route : assert property (cpu_req && cpu_ready && cpu_addr[31:14] == 18'h00000
		|=> tgt_req_r && tgt_sel_r[RG_DBG]) // RL1
		else $error("debug window not routed");

	a_hcr_route : assert property (cpu_req && cpu_ready && cpu_addr[31:15] == 17'h00001
		|=> tgt_sel_r[RG_HCR]) // RL2
		else $error("hart context window not routed");

	a_cmd_refused : assert property (cpu_req && cpu_ready && !cmd_mode && hit[RG_FLASH_CMD]
		|=> cpu_err_r && tgt_sel_r == '0) // RL10
		else $error("command window open in direct-read mode");

	a_map_refused : assert property (cpu_req && cpu_ready && cmd_mode && hit[RG_FLASH_MAP]
		|=> cpu_err_r) // RL9
		else $error("flash map open in command mode");

	a_ext_zero : assert property (cpu_req && cpu_ready && hit[RG_EXTBUS]
		|=> cpu_ack_r && !cpu_err_r && cpu_rdata_r == 32'h0000_0000) // RL7
		else $error("unconnected bus window misanswered");

	a_fwd_ack : assert property (state_r == ST_FWD && tgt_ack |=> cpu_ack_r && !cpu_err_r
		&& cpu_rdata_r == $past(tgt_rdata)) // RL5
		else $error("target answer not passed back");

	// Checked on the edge after each wait step; the step that leaves the wait sees set-up done
	a_sdram_hold : assert property (state_r == ST_HOLD |-> !tgt_req_r && !$past(sdram_ok_r)) // RL20
		else $error("SDRAM touched before set-up finished");

	a_fetch_single : assert property (flash_read_cmd_r == CMD_FAST_SINGLE
		|| $past(srst)) // RL14
		else $error("direct-read fetch is not single-line");

	a_pclk_period : assert property ($rose(periph_clk_r) |-> ##2 $fell(periph_clk_r)) // RL21
		else $error("peripheral clock half period wrong");

endmodule

// [test/sad_tgt_model.sv]
// Target-side model: answers each forwarded request after a chosen latency
`timescale 1ns/1ps
module sad_tgt_model
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  lat,
	input  wire logic        tgt_req_r,
	input  wire logic [31:0] tgt_addr_r,
	output logic             tgt_ack,
	output logic [31:0]      tgt_rdata
);
	logic [7:0]  wait_r;
	logic [31:0] noise_r;

	// Countdown from the request pulse; ack stands for one cycle only
	always_ff @(posedge sys_clk)
	begin
		noise_r <= noise_r + 32'h9E37_79B9;
		if (srst)
		begin
			wait_r  <= 8'h00;
			tgt_ack <= 1'b0;
			noise_r <= 32'h1357_9BDF;
		end
		else
		begin
			tgt_ack <= (tgt_req_r && lat == 8'h00) || (wait_r == 8'h01);
			wait_r  <= tgt_req_r ? lat : ((wait_r != 8'h00) ? wait_r - 8'h01 : 8'h00);
		end
	end

	// Data is only meaningful with ack; otherwise a moving pattern, never the last word
	assign tgt_rdata = tgt_ack ? ~tgt_addr_r : noise_r;
endmodule

// [test/sad_decoder_tb.sv]
// Self-checking bench for the system address decoder
`timescale 1ns/1ps
module sad_decoder_tb;
	import sad_pkg::*;
	logic sys_clk, srst, cpu_req, cpu_we, tgt_ack, sdram_init_done, cpu_ready, cpu_ack_r, cpu_err_r;
	logic tgt_req_r, tgt_we_r, flash_cmd_mode_r, sdram_init_req_r, periph_clk_r, pv;
	logic [31:0] cpu_addr, cpu_wdata, cpu_rdata_r, tgt_addr_r, tgt_wdata_r, tgt_rdata, a;
	logic [NRGN-1:0] tgt_sel_r, s;
	logic [7:0]  flash_read_cmd_r, flash_sck_div_r, lat;
	logic [4:0]  queue_depth_r;
	logic [15:0] i2c_scl_div_r;
	logic [3:0]  i2c_addr_bits_r;
	int          mismatches, checks_done, rises;
	logic [31:0] rsv [0:14] = '{32'h0000_4000, 32'h0001_0000, 32'h0182_0000, 32'h0201_0000,
		32'h0211_0000, 32'h0C40_0000, 32'h2010_0000, 32'h4200_0000, 32'h7001_0000,
		32'hE000_1000, 32'hE200_0000, 32'hE400_7000, 32'hE881_0000, 32'hE891_0000, 32'hFFFF_FFFC};

	sad_decoder dut (.sys_clk(sys_clk), .srst(srst), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
		.cpu_we(cpu_we), .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready), .cpu_ack_r(cpu_ack_r),
		.cpu_err_r(cpu_err_r), .cpu_rdata_r(cpu_rdata_r), .tgt_req_r(tgt_req_r), .tgt_sel_r(tgt_sel_r),
		.tgt_addr_r(tgt_addr_r), .tgt_we_r(tgt_we_r), .tgt_wdata_r(tgt_wdata_r), .tgt_ack(tgt_ack),
		.tgt_rdata(tgt_rdata), .flash_cmd_mode_r(flash_cmd_mode_r), .flash_read_cmd_r(flash_read_cmd_r),
		.flash_sck_div_r(flash_sck_div_r), .queue_depth_r(queue_depth_r), .i2c_scl_div_r(i2c_scl_div_r),
		.i2c_addr_bits_r(i2c_addr_bits_r), .sdram_init_req_r(sdram_init_req_r),
		.sdram_init_done(sdram_init_done), .periph_clk_r(periph_clk_r));
	sad_tgt_model tgt (.sys_clk(sys_clk), .srst(srst), .lat(lat), .tgt_req_r(tgt_req_r),
		.tgt_addr_r(tgt_addr_r), .tgt_ack(tgt_ack), .tgt_rdata(tgt_rdata));

	// 100 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// One word access; request held until the take edge, answer awaited with a bound
	task automatic acc(input logic [31:0] ad, input logic w, input logic [31:0] d, input logic e,
		input logic [31:0] r, input logic [NRGN-1:0] sx);
		int n;
		logic [NRGN-1:0] got;
		got = '0;
		@(posedge sys_clk);
		cpu_req <= 1'b1;
		cpu_addr <= ad;
		cpu_we <= w;
		cpu_wdata <= d;
		@(posedge sys_clk);
		cpu_req <= 1'b0;
		for (n = 0; n < 60; n++)
		begin
			#1;
			if (tgt_req_r === 1'b1)
				got = tgt_sel_r;
			if (cpu_ack_r === 1'b1)
				break;
			@(posedge sys_clk);
		end
		if (n == 60)
		begin
			chk(1'b0, "no answer");
			test_done();
		end
		chk(cpu_err_r === e && cpu_rdata_r === r && got === sx, $sformatf("access %h", ad));
		if (w && sx != '0)
			chk(tgt_we_r === 1'b1 && tgt_wdata_r === d, "write not forwarded");
	endtask

	initial
	begin
		mismatches = 0;
		checks_done = 0;
		{srst, cpu_req, cpu_we, sdram_init_done} = 4'h8;
		cpu_addr = '0;
		cpu_wdata = '0;
		lat = 8'h00;
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(flash_cmd_mode_r === 1'b0, "mode after reset");
		chk(flash_read_cmd_r === CMD_FAST_SINGLE, "fetch command");
		chk(flash_sck_div_r === 8'h01, "flash divider");
		chk(queue_depth_r === 5'h10, "queue depth");
		chk(i2c_scl_div_r === 16'h00FA && i2c_addr_bits_r === 4'h7, "i2c set-up");
		chk(sdram_init_req_r === 1'b1, "sdram init request");
		// SDRAM access before set-up finishes must wait in hold, then go through
		fork
			begin
				repeat (8) @(posedge sys_clk);
				sdram_init_done <= 1'b1;
			end
		join_none
		s = '0;
		s[RG_SDRAM] = 1'b1;
		acc(RGN_BASE[RG_SDRAM], 1'b0, '0, 1'b0, ~RGN_BASE[RG_SDRAM], s);
		chk(sdram_init_done === 1'b1, "sdram answered before set-up");
		// Peripheral clock: 10 rises in 40 system cycles
		rises = 0;
		pv = periph_clk_r;
		repeat (40)
		begin
			@(posedge sys_clk);
			#1;
			rises += (periph_clk_r === 1'b1 && pv === 1'b0);
			pv = periph_clk_r;
		end
		chk(rises == 10, "peripheral clock rate");
		chk(sdram_init_req_r === 1'b0, "sdram init request drop");
		acc(SEL_ADDR, 1'b0, '0, 1'b0, '0, '0);
		// Every window at both ends, direct-read mode selected
		for (int i = 0; i < NRGN; i++)
			for (int k = 0; k < 2; k++)
			begin
				a = RGN_BASE[i] + (k ? (RGN_MASK[i] & ~32'h3) : 32'h0);
				s = '0;
				if (i != int'(RG_EXTBUS) && i != int'(RG_FLASH_CMD))
					s[i] = 1'b1;
				acc(a, 1'b0, '0, i == int'(RG_FLASH_CMD), (s != '0) ? ~a : '0, s);
			end
		foreach (rsv[j])
			acc(rsv[j], 1'b0, '0, 1'b1, '0, '0);
		acc(32'h0000_4000, 1'b1, 32'h1234_5678, 1'b1, '0, '0);
		// Command mode: of the flash windows only its own is served
		acc(SEL_ADDR, 1'b1, 32'hFFFF_FFFF, 1'b0, '0, '0);
		acc(SEL_ADDR, 1'b0, '0, 1'b0, 32'h0000_0002, '0);
		chk(flash_cmd_mode_r === 1'b1, "command mode");
		acc(RGN_BASE[RG_FLASH_MAP], 1'b0, '0, 1'b1, '0, '0);
		acc(RGN_BASE[RG_FLASH_DREG], 1'b0, '0, 1'b1, '0, '0);
		s = '0;
		s[RG_FLASH_CMD] = 1'b1;
		acc(RGN_BASE[RG_FLASH_CMD], 1'b1, 32'hC3C3_3C3C, 1'b0, ~RGN_BASE[RG_FLASH_CMD], s);
		acc(SEL_ADDR, 1'b1, 32'h0000_0000, 1'b0, '0, '0);
		// Mode copy output lags the selector register by one cycle
		@(posedge sys_clk);
		#1;
		chk(flash_cmd_mode_r === 1'b0, "direct mode back");
		// Slow target, plain word write then read to data memory; no atomic pairs issued
		lat = 8'h14;
		s = '0;
		s[RG_DLM] = 1'b1;
		acc(32'h7000_0010, 1'b1, 32'hA5A5_5A5A, 1'b0, ~32'h7000_0010, s);
		acc(32'h7000_0010, 1'b0, '0, 1'b0, ~32'h7000_0010, s);
		test_done();
	end
endmodule
